/* File: common/csm_regs.vh */
// constants for the CAN sleep control block: register map, fields, counts
// assumes a 32-bit AHB-Lite slave with byte addresses on haddr[7:0]
`ifndef CSM_REGS_VH
`define CSM_REGS_VH

// ==========================================
// register byte offsets
`define CSM_A_CTRL 8'h00
`define CSM_A_STAT 8'h04
`define CSM_A_TXE 8'h08
`define CSM_A_ABT 8'h0C
`define CSM_A_RXF 8'h10
`define CSM_A_RXD 8'h14

// ==========================================
// field positions
`define CSM_CTRL_SREQ 0
`define CSM_CTRL_WUEN 1
`define CSM_STAT_ACK 0
`define CSM_STAT_WUIF 1
`define CSM_STAT_BOFF 2
`define CSM_STAT_CLKEN 3
`define CSM_STAT_PEND 4
`define CSM_RXF_FULL 0

// ==========================================
// widths and reset values
`define CSM_NTX 3
`define CSM_TXE_RST 3'h7
`define CSM_ABT_RST 3'h0
`define CSM_ZERO32 32'h0000_0000

// ==========================================
// bus-off recovery: 128 runs of 11 recessive bits
`define CSM_RUN_LEN 4'hB
`define CSM_RUN_NUM 8'h80

// ==========================================
// AHB encodings
`define CSM_HTRANS_NSEQ 1'b1

`endif

/* File: rtl/csm_bus_detect.v */
// CAN receive pin synchroniser and activity detector
// assumes the pin is asynchronous to clock; recessive is high
`timescale 1ns/1ps
`default_nettype none

module csm_bus_detect (
    input wire clock,
    input wire nrst,
    input wire pinIn,
    output wire rxSync,
    output reg activity
);

    reg meta;
    reg sync;
    reg syncDly;

    // ==========================================
    // two-stage synchroniser, first stage read only by second
    always @(posedge clock) begin
        if (!nrst) begin
            meta <= 1'b1;
            sync <= 1'b1;
            syncDly <= 1'b1;
            activity <= 1'b0;
        end else begin
            meta <= pinIn;
            sync <= meta;
            syncDly <= sync;
            // a falling edge means a dominant bit started
            activity <= syncDly & ~sync;
        end
    end

    assign rxSync = sync;

endmodule // csm_bus_detect

`default_nettype wire

/* File: rtl/csm_sleep_ctrl.v */
// sleep request and acknowledge control of a CAN protocol controller
// assumes an AHB-Lite master on the register side and a protocol engine
// that reports transmit completion, reception and bus idle on clock
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "csm_regs.vh"

module csm_sleep_ctrl (
    input wire clock,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire canRxInput,
    output wire canTxOutput,
    input wire engineTxBit,
    output wire engineRxBit,
    input wire rxActive,
    input wire busIdle,
    input wire [2:0] txDone,
    output wire [2:0] abortRequest,
    input wire busOff,
    input wire bitTick,
    output reg busOffRecovered,
    input wire rxFifoValid,
    input wire [31:0] rxFifoData,
    output wire rxFifoPop,
    output wire protoClkEn
);

    localparam ST_AWAKE = 2'b00;
    localparam ST_PEND = 2'b01;
    localparam ST_SLEEP = 2'b10;
    // reset pattern of the empty flags, one bit per buffer
    localparam [2:0] TXE_RST = `CSM_TXE_RST;

    reg [1:0] state;
    reg [1:0] next_state;
    reg sleepRequest;
    reg wakeupEnable;
    reg wakeLatched;
    reg wakeupInterruptFlag;
    reg [2:0] txBufferEmptyFlag;
    reg [2:0] abortReg;
    reg rxBufferFullFlag;
    reg [31:0] rxForegroundBuffer;
    reg [3:0] runCnt;
    reg [7:0] runNum;
    reg dpWrite;
    reg [7:0] dpAddr;

    wire rxSync;
    wire activity;
    wire sleepAcknowledge;
    wire allEmpty;
    wire quiet;
    wire addrPhase;
    wire wrCtrl;
    wire wrStat;
    wire wrTxe;
    wire wrAbt;
    wire wrRxf;
    wire wakeNow;
    wire cpuClear;
    wire cpuSet;

    // ==========================================
    // pin synchroniser and activity detect
    csm_bus_detect u_detect (
        .clock(clock),
        .nrst(nrst),
        .pinIn(canRxInput),
        .rxSync(rxSync),
        .activity(activity)
    );

    // ==========================================
    // AHB-Lite slave: zero wait states, always OKAY
    // a one-cycle answer keeps the slave free of wait-state logic
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrPhase = hsel & hready & htrans[1] == `CSM_HTRANS_NSEQ;

    always @(posedge clock) begin
        if (!nrst) begin
            dpWrite <= 1'b0;
            dpAddr <= 8'h00;
        end else begin
            // address taken every cycle; only the write strobe qualifies it
            dpWrite <= addrPhase & hwrite;
            dpAddr <= haddr[7:0];
        end
    end

    assign wrCtrl = dpWrite & (dpAddr == `CSM_A_CTRL);
    assign wrStat = dpWrite & (dpAddr == `CSM_A_STAT);
    assign wrTxe = dpWrite & (dpAddr == `CSM_A_TXE);
    assign wrAbt = dpWrite & (dpAddr == `CSM_A_ABT);
    assign wrRxf = dpWrite & (dpAddr == `CSM_A_RXF);

    // read data registered in the address phase
    // hsize ignored: every register is one whole word
    always @(posedge clock) begin
        if (!nrst) begin
            hrdata <= `CSM_ZERO32;
        end else if (addrPhase & ~hwrite) begin
            hrdata <= `CSM_ZERO32;
            case (haddr[7:0])
                `CSM_A_CTRL: begin
                    hrdata[`CSM_CTRL_SREQ] <= sleepRequest;
                    hrdata[`CSM_CTRL_WUEN] <= wakeupEnable;
                end
                `CSM_A_STAT: begin
                    hrdata[`CSM_STAT_ACK] <= sleepAcknowledge;
                    hrdata[`CSM_STAT_WUIF] <= wakeupInterruptFlag;
                    hrdata[`CSM_STAT_BOFF] <= busOff;
                    hrdata[`CSM_STAT_CLKEN] <= protoClkEn;
                    hrdata[`CSM_STAT_PEND] <= state == ST_PEND;
                end
                `CSM_A_TXE: hrdata[2:0] <= txBufferEmptyFlag;
                `CSM_A_ABT: hrdata[2:0] <= abortReg;
                `CSM_A_RXF: hrdata[`CSM_RXF_FULL] <= rxBufferFullFlag;
                `CSM_A_RXD: hrdata <= rxForegroundBuffer;
                default: hrdata <= `CSM_ZERO32;
            endcase
        end
    end

    // ==========================================
    // sleep state machine
    // pending is visible in status so software sees the deferral
    assign sleepAcknowledge = state == ST_SLEEP;
    assign allEmpty = &txBufferEmptyFlag;
    assign quiet = allEmpty & ~rxActive & busIdle;
    // wake needs activity and latched enable
    assign wakeNow = sleepAcknowledge & activity & wakeLatched;
    assign cpuSet = wrCtrl & hwdata[`CSM_CTRL_SREQ] & ~wakeupInterruptFlag;
    assign cpuClear = wrCtrl & ~hwdata[`CSM_CTRL_SREQ] & sleepAcknowledge;

    always @* begin
        next_state = state;
        case (state)
            ST_AWAKE: begin
                if (sleepRequest) begin
                    if (quiet) begin
                        next_state = ST_SLEEP;
                    end else begin
                        next_state = ST_PEND;
                    end
                end
            end
            ST_PEND: begin
                if (quiet) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (cpuClear | wakeNow) begin
                    next_state = ST_AWAKE;
                end
            end
            default: next_state = ST_AWAKE;
        endcase
    end

    always @(posedge clock) begin
        if (!nrst) begin
            state <= ST_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================
    // control bits
    always @(posedge clock) begin
        if (!nrst) begin
            sleepRequest <= 1'b0;
            wakeupEnable <= 1'b0;
            wakeLatched <= 1'b0;
        end else begin
            if (wrCtrl) begin
                wakeupEnable <= hwdata[`CSM_CTRL_WUEN];
            end
            // clear wins over set, so a wake cannot re-arm the request
            // hardware clears request on wake
            if (wakeNow | cpuClear) begin
                sleepRequest <= 1'b0;
            end else if (cpuSet) begin
                sleepRequest <= 1'b1;
            end
            // trade-off: a late enable write waits for the next sleep
            // enable sampled at sleep entry
            if (state != ST_SLEEP && next_state == ST_SLEEP) begin
                wakeLatched <= wakeupEnable;
            end
        end
    end

    // wake flag: hardware set wins over software clear
    always @(posedge clock) begin
        if (!nrst) begin
            wakeupInterruptFlag <= 1'b0;
        end else if (wakeNow) begin
            wakeupInterruptFlag <= 1'b1;
        end else if (wrStat & hwdata[`CSM_STAT_WUIF]) begin
            wakeupInterruptFlag <= 1'b0;
        end
    end

    // ==========================================
    // transmit buffers, per-buffer empty and abort bits
    genvar gi;
    generate
        for (gi = 0; gi < `CSM_NTX; gi = gi + 1) begin : g_tx
            always @(posedge clock) begin
                if (!nrst) begin
                    txBufferEmptyFlag[gi] <= TXE_RST[gi];
                    abortReg[gi] <= 1'b0;
                end else begin
                    // done pulse wins over a software clear in one cycle
                    // empty flag clearable asleep
                    if (txDone[gi]) begin
                        txBufferEmptyFlag[gi] <= 1'b1;
                    end else if (wrTxe & hwdata[gi]) begin
                        txBufferEmptyFlag[gi] <= 1'b0;
                    end
                    if (txDone[gi]) begin
                        abortReg[gi] <= 1'b0;
                    end else if (wrAbt & hwdata[gi]) begin
                        abortReg[gi] <= ~txBufferEmptyFlag[gi];
                    end
                end
            end
        end
    endgenerate

    // stored aborts stay pending and go out once awake
    // no abort while asleep
    assign abortRequest = sleepAcknowledge ? `CSM_ABT_RST : abortReg;

    // ==========================================
    // receive foreground buffer
    // the pop wins over a clear, so no message is lost
    // no shift while asleep
    assign rxFifoPop = rxFifoValid & ~rxBufferFullFlag & ~sleepAcknowledge;

    always @(posedge clock) begin
        if (!nrst) begin
            rxBufferFullFlag <= 1'b0;
            rxForegroundBuffer <= `CSM_ZERO32;
        end else if (rxFifoPop) begin
            rxBufferFullFlag <= 1'b1;
            rxForegroundBuffer <= rxFifoData;
        end else if (wrRxf & hwdata[`CSM_RXF_FULL]) begin
            rxBufferFullFlag <= 1'b0;
        end
    end

    // ==========================================
    // pins toward bus and engine
    // sleep never disturbs the bus: transmit forced recessive
    // protocol clocks gated, bus side runs on
    assign protoClkEn = ~sleepAcknowledge;
    assign canTxOutput = sleepAcknowledge | engineTxBit;
    assign engineRxBit = (sleepAcknowledge & ~wakeLatched) | rxSync;

    // ==========================================
    // bus-off recovery counter, a run of recessive bits each
    // limitation: counts only while the protocol clock is enabled
    // a dominant bit restarts the current run
    // hazard: the engine must drop busOff after the pulse or counting goes on
    always @(posedge clock) begin
        if (!nrst) begin
            runCnt <= 4'h0;
            runNum <= 8'h00;
            busOffRecovered <= 1'b0;
        end else begin
            busOffRecovered <= 1'b0;
            if (!busOff) begin
                runCnt <= 4'h0;
                runNum <= 8'h00;
            end else if (protoClkEn & bitTick) begin
                if (!engineRxBit) begin
                    runCnt <= 4'h0;
                end else if (runCnt == `CSM_RUN_LEN - 4'h1) begin
                    runCnt <= 4'h0;
                    if (runNum == `CSM_RUN_NUM - 8'h01) begin
                        runNum <= 8'h00;
                        busOffRecovered <= 1'b1;
                    end else begin
                        runNum <= runNum + 8'h01;
                    end
                end else begin
                    runCnt <= runCnt + 4'h1;
                end
            end
        end
    end

endmodule // csm_sleep_ctrl

`default_nettype wire

/* File: sim/csm_can_node.sv */
// far node on the CAN bus: idle recessive, toggling bits in a frame
// assumes the bench raises frame off the clock edge by NBA
`timescale 1ns/1ps
`default_nettype none
module csm_can_node (
    input wire logic clock,
    input wire logic frame,
    output logic canRx
);
    // bus pulled recessive between frames
    initial canRx = 1'b1;
    always @(posedge clock) begin
        canRx <= frame ? ~canRx : 1'b1;
    end
endmodule // csm_can_node
`default_nettype wire

/* File: sim/csm_sleep_ctrl_sva.sv */
// port checker of the sleep controller
// assumes protoClkEn low means asleep
`timescale 1ns/1ps
`default_nettype none
module csm_sleep_ctrl_sva (
    input wire clock,
    input wire nrst,
    input wire protoClkEn,
    input wire canTxOutput,
    input wire [2:0] abortRequest,
    input wire rxFifoPop,
    input wire rxFifoValid,
    input wire busOffRecovered,
    input wire hreadyout,
    input wire hresp,
    input wire busIdle,
    input wire rxActive
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // ==========================================
    // sleep side effects
    property p_txRec; !protoClkEn |-> canTxOutput; endproperty
    a_txRec: assert property (p_txRec) else $error("tx not recessive asleep");
    property p_noAbt; !protoClkEn |-> abortRequest == 3'h0; endproperty
    a_noAbt: assert property (p_noAbt) else $error("abort asleep");
    property p_noPop; rxFifoPop |-> rxFifoValid && protoClkEn; endproperty
    a_noPop: assert property (p_noPop) else $error("fifo shift asleep");
    property p_boff; !protoClkEn [*2] |-> !busOffRecovered; endproperty
    a_boff: assert property (p_boff) else $error("recovery counted asleep");
    property p_rdy; hreadyout == 1'b1; endproperty
    a_rdy: assert property (p_rdy) else $error("register access stalled");
    property p_okay; $rose(protoClkEn) || $fell(protoClkEn) |-> !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    // entry only once the bus is quiet
    property p_entry; $fell(protoClkEn) |-> $past(busIdle) && !$past(rxActive); endproperty
    a_entry: assert property (p_entry) else $error("sleep entered mid frame");
    property p_hold; rxActive && protoClkEn |=> protoClkEn; endproperty
    a_hold: assert property (p_hold) else $error("sleep during reception");
endmodule // csm_sleep_ctrl_sva
bind csm_sleep_ctrl csm_sleep_ctrl_sva chk_u (.clock(clock), .nrst(nrst), .protoClkEn(protoClkEn),
    .canTxOutput(canTxOutput), .abortRequest(abortRequest), .rxFifoPop(rxFifoPop),
    .rxFifoValid(rxFifoValid), .busOffRecovered(busOffRecovered), .hreadyout(hreadyout),
    .hresp(hresp), .busIdle(busIdle), .rxActive(rxActive));
`default_nettype wire

/* File: sim/csm_sleep_ctrl_tb.sv */
// self-checking bench of the sleep controller over AHB-Lite
// assumes one slave, zero-wait answers are not relied on
`timescale 1ns/1ps
`default_nettype none
`include "csm_regs.vh"
module csm_sleep_ctrl_tb;
    logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, engTx = 0, rxActive = 0, busIdle = 1;
    logic busOff = 0, rxFifoValid = 0, frame = 0;
    logic [1:0] htrans = 0;
    logic [2:0] txDone = 0;
    logic [31:0] haddr = 0, hwdata = 0, rxFifoData = 0, q;
    wire [31:0] hrdata;
    wire [2:0] abortReq;
    wire hreadyout, hresp, canRx, canTx, engRx, boRec, pop, clkEn;
    int failures = 0, n_tests = 0;
    csm_can_node node_u (.clock(clock), .frame(frame), .canRx(canRx));
    csm_sleep_ctrl dut_u (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .canRxInput(canRx), .canTxOutput(canTx),
        .engineTxBit(engTx), .engineRxBit(engRx), .rxActive(rxActive), .busIdle(busIdle),
        .txDone(txDone), .abortRequest(abortReq), .busOff(busOff), .bitTick(1'b1),
        .busOffRecovered(boRec), .rxFifoValid(rxFifoValid), .rxFifoData(rxFifoData),
        .rxFifoPop(pop), .protoClkEn(clkEn));
    initial forever #4 clock = ~clock;
    // ==========================================
    // shared tasks
    task summarize;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // waits for hready high at a rising edge, bounded
    task rdy;
        int i;
        i = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1 && i < 50) begin
            @(posedge clock);
            i++;
        end
        if (i >= 50) begin
            failures++;
            summarize();
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask
    task waitClk(input logic v);
        int i;
        for (i = 0; i < 60 && clkEn !== v; i++) @(posedge clock);
        chk(clkEn, v);
        if (clkEn !== v) summarize();
    endtask
    // counts clock edges up to the recovery pulse, bounded
    task waitRec(output int n, input int lim);
        n = 0;
        while (boRec !== 1'b1 && n < lim) begin
            @(posedge clock);
            n++;
        end
    endtask
    task pulse(input logic [2:0] b);
        @(posedge clock) txDone <= b;
        @(posedge clock) txDone <= 3'h0;
    endtask
    // ==========================================
    // scenarios
    task scQuiet;
        busOff <= 1;
        bus(1, `CSM_A_CTRL, 32'h1);
        waitClk(0);
        bus(0, `CSM_A_STAT, 0);
        chk(q & 32'h9, 32'h1);
        chk(canTx, 1);
        // enable raised only after entry must not arm a wake
        bus(1, `CSM_A_CTRL, 32'h3);
        frame <= 1;
        repeat (8) @(posedge clock) chk(engRx, 1);
        frame <= 0;
        chk(clkEn, 0);
        bus(1, `CSM_A_CTRL, 32'h0);
        waitClk(1);
        bus(0, `CSM_A_STAT, 0);
        chk(q & 32'h9, 32'h8);
        chk(canTx, 0);
        busOff <= 0;
    endtask
    task scTx;
        bus(1, `CSM_A_TXE, 32'h1);
        // let the scheduled transmit start before asking for sleep
        repeat (4) @(posedge clock);
        bus(1, `CSM_A_CTRL, 32'h1);
        bus(0, `CSM_A_STAT, 0);
        chk(q & 32'h11, 32'h10);
        // a clear before acknowledge must not land
        bus(1, `CSM_A_CTRL, 32'h0);
        bus(0, `CSM_A_CTRL, 0);
        chk(q & 32'h1, 32'h1);
        pulse(3'h1);
        waitClk(0);
        bus(1, `CSM_A_TXE, 32'h2);
        bus(0, `CSM_A_TXE, 0);
        chk(q, 32'h5);
        bus(1, `CSM_A_ABT, 32'h2);
        // look once the stored abort has landed
        @(posedge clock);
        chk(abortReq, 3'h0);
        bus(1, `CSM_A_CTRL, 32'h0);
        waitClk(1);
        chk(abortReq, 3'h2);
        pulse(3'h2);
    endtask
    task scRx;
        rxFifoData <= 32'hA5A5_0001;
        rxFifoValid <= 1;
        rxActive <= 1;
        busIdle <= 0;
        bus(1, `CSM_A_CTRL, 32'h1);
        repeat (6) @(posedge clock);
        chk(clkEn, 1);
        rxActive <= 0;
        busIdle <= 1;
        waitClk(0);
        bus(0, `CSM_A_RXD, 0);
        chk(q, 32'hA5A5_0001);
        bus(1, `CSM_A_RXF, 32'h1);
        bus(0, `CSM_A_RXF, 0);
        chk(q, 32'h0);
        chk(pop, 0);
        bus(1, `CSM_A_CTRL, 32'h0);
        waitClk(1);
        rxFifoValid <= 0;
    endtask
    task scWake;
        // wake enable goes in with the request, before entry
        bus(1, `CSM_A_CTRL, 32'h3);
        waitClk(0);
        frame <= 1;
        waitClk(1);
        frame <= 0;
        bus(0, `CSM_A_STAT, 0);
        chk(q & 32'h3, 32'h2);
        bus(0, `CSM_A_CTRL, 0);
        chk(q & 32'h1, 32'h0);
        bus(1, `CSM_A_CTRL, 32'h3);
        bus(0, `CSM_A_CTRL, 0);
        chk(q & 32'h1, 32'h0);
        bus(1, `CSM_A_STAT, 32'h2);
        bus(0, `CSM_A_STAT, 0);
        chk(q & 32'h2, 32'h0);
        bus(0, 8'h40, 0);
        chk(q, 32'h0);
    endtask
    task scBoff;
        int n;
        @(posedge clock) busOff <= 1;
        waitRec(n, 1500);
        chk(n, 32'h1 + `CSM_RUN_NUM * `CSM_RUN_LEN);
        bus(1, `CSM_A_CTRL, 32'h1);
        waitClk(0);
        // longer than a whole recovery, so only the freeze keeps it quiet
        waitRec(n, 1500);
        chk(boRec, 0);
        bus(1, `CSM_A_CTRL, 32'h0);
        waitClk(1);
        waitRec(n, 1500);
        chk(boRec, 1);
        busOff <= 0;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1;
        bus(0, `CSM_A_TXE, 0);
        chk(q, 32'h7);
        scQuiet();
        scTx();
        scRx();
        scWake();
        scBoff();
        summarize();
    end
endmodule // csm_sleep_ctrl_tb
`default_nettype wire
